// ===== shared/acqss_pkg.sv
package acqss_pkg;
  // sizes
  localparam int unsigned SET_NUM = 32;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned CNT_W = 6;
  localparam int unsigned SHADE_W = 4;
  localparam int unsigned GAIN_W = 8;
  localparam int unsigned EXPO_W = 24;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FEAT = 8'h04;
  localparam logic [7:0] OFF_EDIT_IDX = 8'h08;
  localparam logic [7:0] OFF_TOTAL = 8'h0c;
  localparam logic [7:0] OFF_SHADE = 8'h10;
  localparam logic [7:0] OFF_GAIN = 8'h14;
  localparam logic [7:0] OFF_EXPO = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_REWIND = 8'h20;
  localparam logic [7:0] OFF_BOOT = 8'h24;

  // ctrl fields
  localparam int unsigned CTRL_APPLY_BIT = 0;
  localparam int unsigned CTRL_EDIT_BIT = 1;
  localparam int unsigned CTRL_TRIG_BIT = 2;
  // feature register: pick in [1:0], join flags read back in [10:8]
  localparam int unsigned FEAT_JOIN_BIT = 4;
  localparam int unsigned FEAT_FLAGS_LSB = 8;
  // status: busy flag bit
  localparam int unsigned STAT_BUSY_BIT = 8;

  // defaults: shade, gain and expo also loaded into the edit staging register on entering edit mode, total at reset only
  localparam logic [SHADE_W-1:0] DEF_SHADE = 4'h0;
  localparam logic [GAIN_W-1:0] DEF_GAIN = 8'h01;
  localparam logic [EXPO_W-1:0] DEF_EXPO = 24'h002710;
  localparam logic [CNT_W-1:0] DEF_TOTAL = 6'h01;
  localparam logic [CNT_W-1:0] MAX_TOTAL = 6'h20;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    FEAT_SHADE = 2'b00,
    FEAT_GAIN = 2'b01,
    FEAT_EXPO = 2'b10
  } acqss_feat_t;

  typedef struct packed {
    logic [SHADE_W-1:0] shade;
    logic [GAIN_W-1:0] gain;
    logic [EXPO_W-1:0] expo;
  } acqss_set_t;

  typedef struct packed {
    logic shade;
    logic gain;
    logic expo;
  } acqss_join_t;
endpackage

// ===== hdl/acqss_store.sv
`timescale 1ns/1ps
// parameter set storage: one write port, two read ports
module acqss_store
  import acqss_pkg::*;
#(
  parameter int unsigned DEPTH = SET_NUM
) (
  // clock
  input wire logic clk_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [IDX_W-1:0] wr_idx_i,
  input wire acqss_set_t wr_data_i,
  // read ports
  input wire logic [IDX_W-1:0] rd_a_idx_i,
  output acqss_set_t rd_a_data_o,
  input wire logic [IDX_W-1:0] rd_b_idx_i,
  output acqss_set_t rd_b_data_o
);
  // no reset on the array: contents come from the boot load after reset
  acqss_set_t mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_idx_i] <= wr_data_i;
    end
  end

  always_comb begin
    rd_a_data_o = mem[rd_a_idx_i];
    rd_b_data_o = mem[rd_b_idx_i];
  end
endmodule

// ===== hdl/acqss_top.sv
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
// Summary of operation
// - sequencing on with trigger bit set and edit off: each acquisition advances the set
// - thirty-two sets, indexed zero to thirty-one
// - feature picker selects shading, gain or exposure
// - join flag gates feature from active set
// - edit index chooses set receiving written values
// - read-only current set index readout
// - set total one to thirty-two sets rotate
// - rewind returns to set zero any time
// - entering edit enables all, loads defaults
// - after reset, sets restored per boot profile
module acqss_top
  import acqss_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // acquisition
  input wire logic acq_start_i,
  // boot restore from non-volatile storage
  output logic boot_req_o,
  output logic [1:0] boot_profile_pick_o,
  output logic [IDX_W-1:0] boot_idx_o,
  input wire logic boot_valid_i,
  input wire acqss_set_t boot_data_i,
  input wire logic boot_done_i,
  // applied parameters
  output acqss_set_t applied_o,
  output acqss_join_t join_o
);
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_RUN = 2'b01
  } acqss_state_t;

  acqss_state_t state_reg;
  logic apply_reg, edit_reg, trig_reg;
  acqss_feat_t pick_reg;
  acqss_join_t join_reg;
  logic [IDX_W-1:0] edit_idx_reg, cur_reg, boot_idx_reg;
  logic [CNT_W-1:0] total_reg;
  logic [1:0] boot_pick_reg;
  acqss_set_t shade_gain_expo_reg;
  acqss_set_t applied_reg;

  // axi handshake state
  logic aw_hold_reg, w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg, arready_reg, rvalid_reg;
  logic awready_reg, wready_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  logic wr_fire;
  logic edit_entry;
  logic [31:0] wd;
  logic wr_mem;
  logic wr_ok;
  acqss_set_t wr_set, rd_edit, rd_cur;
  logic [IDX_W-1:0] cur_next;

  assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wd = w_data_reg;
  assign edit_entry = wr_fire && aw_addr_reg == OFF_CTRL && w_strb_reg[0] &&
                      wd[CTRL_EDIT_BIT] && !edit_reg;

  // ---------------- write channel ----------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_hold_reg) begin
        aw_hold_reg <= 1'b1;
        awready_reg <= 1'b0;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_reg) begin
        w_hold_reg <= 1'b1;
        wready_reg <= 1'b0;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    unique case (aw_addr_reg)
      OFF_CTRL, OFF_FEAT, OFF_EDIT_IDX, OFF_TOTAL, OFF_SHADE, OFF_GAIN, OFF_EXPO,
      OFF_REWIND, OFF_BOOT: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // ---------------- control registers ----------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      apply_reg <= 1'b0;
      edit_reg <= 1'b0;
      trig_reg <= 1'b0;
      pick_reg <= FEAT_SHADE;
      join_reg <= '{shade: 1'b1, gain: 1'b1, expo: 1'b1};
      edit_idx_reg <= '0;
      total_reg <= DEF_TOTAL;
      boot_pick_reg <= 2'b00;
    end else if (wr_fire && w_strb_reg[0]) begin
      unique case (aw_addr_reg)
        OFF_CTRL: begin
          apply_reg <= wd[CTRL_APPLY_BIT];
          edit_reg <= wd[CTRL_EDIT_BIT];
          trig_reg <= wd[CTRL_TRIG_BIT];
          if (edit_entry) begin
            join_reg <= '{shade: 1'b1, gain: 1'b1, expo: 1'b1};
          end
        end
        OFF_FEAT: begin
          if (wd[1:0] != 2'b11) begin
            pick_reg <= acqss_feat_t'(wd[1:0]);
          end
          // participation is frozen while editing
          if (!edit_reg) begin
            unique case (acqss_feat_t'(wd[1:0]))
              FEAT_SHADE: join_reg.shade <= wd[FEAT_JOIN_BIT];
              FEAT_GAIN: join_reg.gain <= wd[FEAT_JOIN_BIT];
              FEAT_EXPO: join_reg.expo <= wd[FEAT_JOIN_BIT];
              default: ;
            endcase
          end
        end
        OFF_EDIT_IDX: edit_idx_reg <= wd[IDX_W-1:0];
        OFF_TOTAL: begin
          if (wd[CNT_W-1:0] != '0 && wd[CNT_W-1:0] <= MAX_TOTAL) begin
            total_reg <= wd[CNT_W-1:0];
          end
        end
        OFF_BOOT: boot_pick_reg <= wd[1:0];
        default: ;
      endcase
    end
  end

  // ---------------- edit staging ----------------
  // staged values only take the defaults; a write updates one field of the edited set and stores
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shade_gain_expo_reg <= '{shade: DEF_SHADE, gain: DEF_GAIN, expo: DEF_EXPO};
    end else if (edit_entry) begin
      shade_gain_expo_reg <= '{shade: DEF_SHADE, gain: DEF_GAIN, expo: DEF_EXPO};
    end
  end

  always_comb begin
    wr_set = rd_edit;
    wr_mem = 1'b0;
    // the store port belongs to the boot load until it is done
    if (wr_fire && edit_reg && state_reg == ST_RUN) begin
      unique case (aw_addr_reg)
        OFF_SHADE: begin
          wr_set.shade = wd[SHADE_W-1:0];
          wr_mem = 1'b1;
        end
        OFF_GAIN: begin
          wr_set.gain = wd[GAIN_W-1:0];
          wr_mem = 1'b1;
        end
        OFF_EXPO: begin
          wr_set.expo = wd[EXPO_W-1:0];
          wr_mem = 1'b1;
        end
        default: ;
      endcase
    end
  end

  // ---------------- boot restore ----------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_BOOT;
      boot_idx_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_BOOT: begin
          if (boot_valid_i) begin
            boot_idx_reg <= boot_idx_reg + 1'b1;
          end
          if (boot_done_i) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: ;
        default: state_reg <= ST_BOOT;
      endcase
    end
  end

  logic st_wr;
  logic [IDX_W-1:0] st_idx;
  acqss_set_t st_data;
  assign st_wr = (state_reg == ST_BOOT) ? boot_valid_i : wr_mem;
  assign st_idx = (state_reg == ST_BOOT) ? boot_idx_reg : edit_idx_reg;
  assign st_data = (state_reg == ST_BOOT) ? boot_data_i : wr_set;

  acqss_store #(
    .DEPTH(SET_NUM)
  ) u_store (
    .clk_i(clk_i),
    .wr_en_i(st_wr),
    .wr_idx_i(st_idx),
    .wr_data_i(st_data),
    .rd_a_idx_i(edit_idx_reg),
    .rd_a_data_o(rd_edit),
    .rd_b_idx_i(cur_next),
    .rd_b_data_o(rd_cur)
  );

  // ---------------- sequencing ----------------
  logic rewind;
  logic step;
  assign rewind = wr_fire && aw_addr_reg == OFF_REWIND && w_strb_reg[0] && wd[0];
  // free-running acquisition never steps the set
  assign step = acq_start_i && apply_reg && trig_reg && !edit_reg &&
                state_reg == ST_RUN;

  always_comb begin
    cur_next = cur_reg;
    if (rewind) begin
      cur_next = '0;
    end else if (step) begin
      if ({1'b0, cur_reg} >= total_reg - 1'b1) begin
        cur_next = '0;
      end else begin
        cur_next = cur_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // applied set follows the next index so a fresh acquisition sees it at once
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      applied_reg <= '{shade: DEF_SHADE, gain: DEF_GAIN, expo: DEF_EXPO};
    end else if (apply_reg && !edit_reg && state_reg == ST_RUN) begin
      applied_reg <= rd_cur;
    end
  end

  // ---------------- read channel ----------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (s_axi_araddr)
      OFF_CTRL: begin
        rd_mux[CTRL_APPLY_BIT] = apply_reg;
        rd_mux[CTRL_EDIT_BIT] = edit_reg;
        rd_mux[CTRL_TRIG_BIT] = trig_reg;
      end
      OFF_FEAT: begin
        rd_mux[1:0] = pick_reg;
        unique case (pick_reg)
          FEAT_SHADE: rd_mux[FEAT_JOIN_BIT] = join_reg.shade;
          FEAT_GAIN: rd_mux[FEAT_JOIN_BIT] = join_reg.gain;
          FEAT_EXPO: rd_mux[FEAT_JOIN_BIT] = join_reg.expo;
          default: ;
        endcase
        rd_mux[FEAT_FLAGS_LSB +: 3] = join_reg;
      end
      OFF_EDIT_IDX: rd_mux[IDX_W-1:0] = edit_idx_reg;
      OFF_TOTAL: rd_mux[CNT_W-1:0] = total_reg;
      OFF_SHADE: rd_mux[SHADE_W-1:0] = rd_edit.shade;
      OFF_GAIN: rd_mux[GAIN_W-1:0] = rd_edit.gain;
      OFF_EXPO: rd_mux[EXPO_W-1:0] = rd_edit.expo;
      OFF_STATUS: begin
        rd_mux[IDX_W-1:0] = cur_reg;
        rd_mux[STAT_BUSY_BIT] = (state_reg == ST_BOOT);
      end
      OFF_BOOT: rd_mux[1:0] = boot_pick_reg;
      default: ;
    endcase
  end

  logic rd_ok;
  assign rd_ok = s_axi_araddr == OFF_CTRL || s_axi_araddr == OFF_FEAT ||
                 s_axi_araddr == OFF_EDIT_IDX || s_axi_araddr == OFF_TOTAL ||
                 s_axi_araddr == OFF_SHADE || s_axi_araddr == OFF_GAIN ||
                 s_axi_araddr == OFF_EXPO || s_axi_araddr == OFF_STATUS ||
                 s_axi_araddr == OFF_REWIND || s_axi_araddr == OFF_BOOT;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else begin
      arready_reg <= 1'b0;
      if (s_axi_arvalid && !arready_reg && !rvalid_reg) begin
        arready_reg <= 1'b1;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ---------------- outputs ----------------
  logic [1:0] boot_pick_out_reg;
  logic boot_req_reg;
  logic [IDX_W-1:0] boot_idx_out_reg;
  acqss_join_t join_out_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_req_reg <= 1'b0;
      boot_pick_out_reg <= 2'b00;
      boot_idx_out_reg <= '0;
      join_out_reg <= '{shade: 1'b0, gain: 1'b0, expo: 1'b0};
    end else begin
      boot_req_reg <= (state_reg == ST_BOOT) && !boot_done_i;
      boot_pick_out_reg <= boot_pick_reg;
      boot_idx_out_reg <= boot_idx_reg;
      join_out_reg <= (apply_reg && !edit_reg) ? join_reg : '0;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign boot_req_o = boot_req_reg;
  assign boot_profile_pick_o = boot_pick_out_reg;
  assign boot_idx_o = boot_idx_out_reg;
  assign applied_o = applied_reg;
  assign join_o = join_out_reg;

  // ---------------- assertions ----------------
  AST_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
    step && !rewind && {1'b0, cur_reg} == total_reg - 1'b1 |=> cur_reg == '0)
    else $error("set index did not wrap to zero");
  AST_ADVANCE: assert property (@(posedge clk_i) disable iff (rst_i)
    step && !rewind && {1'b0, cur_reg} < total_reg - 1'b1 |=> cur_reg == $past(cur_reg) + 1'b1)
    else $error("set index did not advance");
  AST_REWIND: assert property (@(posedge clk_i) disable iff (rst_i)
    rewind |=> cur_reg == '0)
    else $error("rewind did not return to set zero");
  AST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !step && !rewind |=> $stable(cur_reg))
    else $error("set index moved without trigger");
  AST_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
    {1'b0, cur_reg} < total_reg || $changed(total_reg) || $past(total_reg) != total_reg)
    else $error("set index beyond set total");
  AST_TOTAL: assert property (@(posedge clk_i) disable iff (rst_i)
    total_reg != '0 && total_reg <= MAX_TOTAL)
    else $error("set total out of range");
  AST_EDIT_DEF: assert property (@(posedge clk_i) disable iff (rst_i)
    edit_entry |=> join_reg == 3'b111 && shade_gain_expo_reg.expo == DEF_EXPO)
    else $error("edit entry defaults not applied");
  AST_BOOT_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_RUN |=> !boot_req_o)
    else $error("boot request after restore");
  AST_JOIN_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    !apply_reg |=> join_o == '0)
    else $error("features joined while sequencing off");
  AST_EDIT_STORE: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_mem |-> edit_reg && state_reg == ST_RUN)
    else $error("set store outside edit mode");

  COV_WRAP: cover property (@(posedge clk_i) disable iff (rst_i)
    step && cur_next == '0 && cur_reg != '0);
  COV_REWIND: cover property (@(posedge clk_i) disable iff (rst_i) rewind && cur_reg != '0);
  COV_EDIT: cover property (@(posedge clk_i) disable iff (rst_i) edit_entry ##[1:50] wr_mem);
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import acqss_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic acq_start_i = 1'b0;
  logic boot_req_o;
  logic [1:0] boot_profile_pick_o;
  logic [IDX_W-1:0] boot_idx_o;
  logic boot_valid_i = 1'b0;
  acqss_set_t boot_data_i = '0;
  logic boot_done_i = 1'b0;
  acqss_set_t applied_o;
  acqss_join_t join_o;
  int n_fail = 0;
  int num_checks = 0;
  logic [31:0] d;

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  acqss_top u_acqss_top (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .acq_start_i(acq_start_i),
    .boot_req_o(boot_req_o),
    .boot_profile_pick_o(boot_profile_pick_o),
    .boot_idx_o(boot_idx_o),
    .boot_valid_i(boot_valid_i),
    .boot_data_i(boot_data_i),
    .boot_done_i(boot_done_i),
    .applied_o(applied_o),
    .join_o(join_o)
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic hang(input int n);
    if (n > 200) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, n, 200);
      test_done();
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_set(input acqss_set_t got, input acqss_set_t exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // write address and data offered together, bready held up until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
      n++;
      hang(n);
    end
    s_axi_bready <= 1'b0;
    chk_word({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
      n++;
      hang(n);
    end
    v = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk_word({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  task automatic acq();
    @(posedge clk_i);
    acq_start_i <= 1'b1;
    @(posedge clk_i);
    acq_start_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  function automatic acqss_set_t bset(input int i);
    return {i[3:0], 8'h80 | i[7:0], 24'h100000 + i[23:0]};
  endfunction

  function automatic acqss_set_t eset(input int i);
    return {i[3:0], 8'(i + 1), 24'((i + 1) * 10000)};
  endfunction

  initial begin
    int n;
    int tv[4] = '{0, 33, 32, 4};
    int te[4] = '{1, 1, 32, 4};
    acqss_set_t s;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    n = 0;
    while (boot_req_o !== 1'b1) begin
      @(posedge clk_i);
      n++;
      hang(n);
    end
    // restore every set from storage, the walk of boot_idx_o is checked
    for (int i = 0; i < SET_NUM; i++) begin
      @(posedge clk_i);
      chk_word(32'(boot_idx_o), i);
      boot_valid_i <= 1'b1;
      boot_data_i <= bset(i);
      @(posedge clk_i);
      boot_valid_i <= 1'b0;
      // the index output trails the store by one edge
      @(posedge clk_i);
    end
    @(posedge clk_i);
    boot_done_i <= 1'b1;
    @(posedge clk_i);
    boot_done_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk_word({31'h0, boot_req_o}, 32'h0);
    rd(OFF_STATUS, RESP_OKAY, d);
    chk_word(d & 32'h1ff, 32'h0);
    $display("test boot restore done");

    for (int p = 0; p < 3; p++) begin
      wr(OFF_FEAT, 32'h10 | p, RESP_OKAY);
    end
    wr(OFF_CTRL, 32'h2, RESP_OKAY);
    rd(OFF_FEAT, RESP_OKAY, d);
    chk_word(d & 32'h700, 32'h700);
    chk_word({29'h0, join_o}, 32'h0);
    wr(OFF_EDIT_IDX, 32'd31, RESP_OKAY);
    s = bset(31);
    rd(OFF_SHADE, RESP_OKAY, d);
    chk_word(d, 32'(s.shade));
    rd(OFF_GAIN, RESP_OKAY, d);
    chk_word(d, 32'(s.gain));
    rd(OFF_EXPO, RESP_OKAY, d);
    chk_word(d, 32'(s.expo));
    for (int i = 0; i < 4; i++) begin
      wr(OFF_EDIT_IDX, i, RESP_OKAY);
      wr(OFF_SHADE, i, RESP_OKAY);
      wr(OFF_GAIN, i + 1, RESP_OKAY);
      wr(OFF_EXPO, (i + 1) * 10000, RESP_OKAY);
    end
    for (int i = 0; i < 4; i++) begin
      wr(OFF_EDIT_IDX, i, RESP_OKAY);
      rd(OFF_EXPO, RESP_OKAY, d);
      chk_word(d, 32'(eset(i).expo));
    end
    for (int i = 0; i < 4; i++) begin
      wr(OFF_TOTAL, tv[i], RESP_OKAY);
      rd(OFF_TOTAL, RESP_OKAY, d);
      chk_word(d & 32'h3f, te[i]);
    end
    $display("test set editing done");

    wr(OFF_CTRL, 32'h5, RESP_OKAY);
    for (int k = 1; k < 10; k++) begin
      acq();
      rd(OFF_STATUS, RESP_OKAY, d);
      chk_word(d & 32'h1ff, k % 4);
      chk_set(applied_o, eset(k % 4));
      chk_word({29'h0, join_o}, 32'h7);
    end
    // rewind in mid-cycle, then the rotation resumes from set zero
    wr(OFF_REWIND, 32'h1, RESP_OKAY);
    rd(OFF_STATUS, RESP_OKAY, d);
    chk_word(d & 32'h1ff, 32'h0);
    chk_set(applied_o, eset(0));
    acq();
    rd(OFF_STATUS, RESP_OKAY, d);
    chk_word(d & 32'h1ff, 32'h1);
    $display("test sequencing done");

    wr(OFF_CTRL, 32'h1, RESP_OKAY);
    acq();
    rd(OFF_STATUS, RESP_OKAY, d);
    chk_word(d & 32'h1ff, 32'h1);
    wr(OFF_CTRL, 32'h0, RESP_OKAY);
    wr(OFF_FEAT, 32'h01, RESP_OKAY);
    wr(OFF_CTRL, 32'h5, RESP_OKAY);
    repeat (2) @(posedge clk_i);
    chk_word({29'h0, join_o}, 32'h5);
    $display("test trigger and join done");

    wr(OFF_BOOT, 32'h2, RESP_OKAY);
    // a write without byte lane zero must leave the register alone
    s_axi_wstrb <= 4'he;
    wr(OFF_BOOT, 32'h1, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(OFF_BOOT, RESP_OKAY, d);
    chk_word(d, 32'h2);
    chk_word({30'h0, boot_profile_pick_o}, 32'h2);
    $display("test boot profile done");

    wr(8'h40, 32'h1, RESP_SLVERR);
    rd(8'h40, RESP_SLVERR, d);
    chk_word(d, 32'h0);
    $display("test unmapped access done");
    test_done();
  end
endmodule
